// File: verilog/fpd_panel.sv
// module: front panel display drivers, lightbars, knob counter and buttons
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module fpd_panel (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// host bus
	fpd_bus_if.device bus,
	// knob phases and buttons
	input wire logic knobPhaseA,
	input wire logic knobPhaseB,
	input wire logic [3:0] panelSwitchInputs,
	// display drive
	output logic [7:0] displaySelectN,
	output logic [9:0] segmentDrive,
	output logic [10:0] lightbarDrive
);
	// ----------------------------------------
	// latches
	// ----------------------------------------
	logic [3:0] selectLatch;
	logic [7:0] lowerSeg;
	logic [7:0] upperSeg;
	logic [7:0] lightbarLatch;
	logic [3:0] knobCount;
	logic [2:0] shapeA;
	logic [2:0] shapeB;
	logic levelA;
	logic levelB;
	logic [7:0] next_readData;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// strobes are one cycle wide, so each access is seen exactly once
	wire logic busWrite = bus.writeStrobe;
	wire logic anyAccess = bus.writeStrobe | bus.readStrobe;

	// ----------------------------------------
	// display select
	// ----------------------------------------
	// one-hot low decode of the select index
	// all outputs high while the enable bit is low, so nothing is lit
	function automatic logic [7:0] decodeSelect(input logic [3:0] sel);
		logic [7:0] onehot;
		onehot = 8'hFF;
		if (sel[fpd_pkg::SELECT_ENABLE_BIT]) begin
			onehot[sel[2:0]] = 1'b0;
		end
		return onehot;
	endfunction

	// select latch; zero in enable bit blanks everything
	// an enabled write with a new index moves the lit display in one step
	// the index is only loaded, never counted: the host owns the order
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			selectLatch <= fpd_pkg::SELECT_RESET;
		end else if (busWrite && bus.address == fpd_pkg::LOC_SELECT) begin
			selectLatch <= bus.writeData[3:0];
		end
	end

	// ----------------------------------------
	// segment and lightbar latches
	// ----------------------------------------
	// a latch keeps its value until the next write, blank or reset
	// blanking clears all three at the edge of the select write
	// segment and lightbar latches, cleared by reset or blanking
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lowerSeg <= fpd_pkg::LATCH_RESET;
			upperSeg <= fpd_pkg::LATCH_RESET;
			lightbarLatch <= fpd_pkg::LATCH_RESET;
		end else if (busWrite && bus.address == fpd_pkg::LOC_SELECT &&
				!bus.writeData[fpd_pkg::SELECT_ENABLE_BIT]) begin
			lowerSeg <= fpd_pkg::LATCH_RESET;
			upperSeg <= fpd_pkg::LATCH_RESET;
			lightbarLatch <= fpd_pkg::LATCH_RESET;
		end else if (busWrite) begin
			if (bus.address == fpd_pkg::LOC_LOWER_SEG) begin
				lowerSeg <= bus.writeData;
			end
			if (bus.address == fpd_pkg::LOC_UPPER_SEG) begin
				upperSeg <= bus.writeData;
			end
			if (bus.address == fpd_pkg::LOC_LIGHTBAR) begin
				lightbarLatch <= bus.writeData;
			end
		end
	end

	// ----------------------------------------
	// drive outputs
	// ----------------------------------------
	// one flop stage after the latches keeps every pin free of glitches
	// a full-size lightbar takes two bits, one for each half
	// registered drive outputs
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			displaySelectN <= 8'hFF;
			segmentDrive <= 10'h000;
			lightbarDrive <= 11'h000;
		end else begin
			displaySelectN <= decodeSelect(selectLatch);
			segmentDrive <= {upperSeg[fpd_pkg::UPPER_SEG_LSB +: 2], lowerSeg};
			// each bit drives one half of a split lightbar
			lightbarDrive <= {upperSeg[fpd_pkg::UPPER_BAR_LSB +: 3], lightbarLatch};
		end
	end

	// ----------------------------------------
	// control knob
	// ----------------------------------------
	// the inversion mirrors the input stage, so an idle high pin is level low
	// a pulse shorter than two clocks never reaches the level flops
	// phase B is shaped the same way so both phases see equal delay
	// knob shaping: sync, invert, require two equal samples
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			shapeA <= 3'h0;
			shapeB <= 3'h0;
			levelA <= 1'b0;
			levelB <= 1'b0;
		end else begin
			shapeA <= {shapeA[1:0], ~knobPhaseA};
			shapeB <= {shapeB[1:0], ~knobPhaseB};
			if (shapeA[2] == shapeA[1]) begin
				levelA <= shapeA[2];
			end
			if (shapeB[2] == shapeB[1]) begin
				levelB <= shapeB[2];
			end
		end
	end

	// a clear and a step in one cycle: the clear wins and the step is lost
	// the counter wraps silently; the host must poll often enough
	// up/down knob counter, cleared by access to location 4
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			knobCount <= fpd_pkg::KNOB_PRELOAD;
		end else if (anyAccess && bus.address == fpd_pkg::LOC_KNOB_CLEAR) begin
			knobCount <= fpd_pkg::KNOB_PRELOAD;
		end else if (levelA == 1'b0 && shapeA[2] == 1'b1 && shapeA[1] == 1'b1) begin
			// rising shaped phase A; phase B high means clockwise
			if (levelB) begin
				knobCount <= knobCount + 4'h1;
			end else begin
				knobCount <= knobCount - 4'h1;
			end
		end
	end

	// ----------------------------------------
	// front panel input buffer
	// ----------------------------------------
	// only the buffer location returns data; every other read gives zero
	// buttons pass straight through; debouncing is left to the host
	// read mux
	always_comb begin
		next_readData = 8'h00;
		if (bus.readStrobe && bus.address == fpd_pkg::LOC_PANEL_INPUT) begin
			next_readData[2:0] = knobCount[3:1];
			next_readData[5:3] = panelSwitchInputs[2:0];
			next_readData[fpd_pkg::PANEL_SPARE_BIT] = 1'b1;
			next_readData[7] = panelSwitchInputs[3];
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	// zero between reads, so a stale value is never taken twice
	// read data stands one cycle after the strobe
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bus.readData <= 8'h00;
		end else begin
			bus.readData <= next_readData;
		end
	end
endmodule : fpd_panel
`default_nettype wire

// File: verilog/fpd_pkg.sv
// package: front panel display and knob constants
package fpd_pkg;
	// ----------------------------------------
	// decoded locations
	// ----------------------------------------
	localparam logic [2:0] LOC_SELECT = 3'h0;
	localparam logic [2:0] LOC_LOWER_SEG = 3'h1;
	localparam logic [2:0] LOC_UPPER_SEG = 3'h2;
	localparam logic [2:0] LOC_LIGHTBAR = 3'h3;
	localparam logic [2:0] LOC_KNOB_CLEAR = 3'h4;
	localparam logic [2:0] LOC_PANEL_INPUT = 3'h5;
	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int SELECT_ENABLE_BIT = 3;
	localparam int UPPER_SEG_LSB = 0;
	localparam int UPPER_BAR_LSB = 2;
	localparam int PANEL_SPARE_BIT = 6;
	localparam logic [3:0] SELECT_RESET = 4'h0;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [3:0] KNOB_PRELOAD = 4'h0;
	// ----------------------------------------
	// host timing
	// ----------------------------------------
	localparam int CLOCK_MHZ = 250;
	localparam int REFRESH_US_X10 = 25; // 2.5 ms per display, in tenths of a ms
	localparam int REFRESH_CYCLES = REFRESH_US_X10 * 100 * CLOCK_MHZ;
	localparam int DISPLAY_COUNT = 8;
	localparam int DEBOUNCE_READS = 4;
endpackage : fpd_pkg

// File: verilog/fpd_bus_if.sv
// interface: parallel bus between host and front panel
`timescale 1ns/1ps
`default_nettype none
interface fpd_bus_if;
	logic [2:0] address;
	logic [7:0] writeData;
	logic writeStrobe;
	logic readStrobe;
	logic [7:0] readData;
	modport device (input address, writeData, writeStrobe, readStrobe, output readData);
	modport host (output address, writeData, writeStrobe, readStrobe, input readData);
endinterface : fpd_bus_if
`default_nettype wire

// File: verilog/fpd_host.sv
// module: host end, refreshes displays and polls the panel
`timescale 1ns/1ps
`default_nettype none
module fpd_host #(
	// cycles each display stays lit; shortened only to keep a test brief
	parameter int REFRESH_CYCLES = fpd_pkg::REFRESH_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// host bus
	fpd_bus_if.host bus,
	// user side
	input wire logic [9:0] digitSegments [8],
	input wire logic [7:0] lightbarWord,
	input wire logic [2:0] upperBars,
	output logic [15:0] turnCount,
	output logic [3:0] pressedSwitches
);
	typedef enum {ST_BLANK, ST_SELECT, ST_LOWER, ST_UPPER, ST_BAR, ST_WAIT, ST_READ, ST_TAKE,
		ST_CLEAR} fpd_state_type;
	fpd_state_type state;
	logic [2:0] digit;
	logic [31:0] waitCount;
	logic [3:0] lastButtons;
	logic [3:0] stableCount;

	// one display per refresh period, then poll and clear knob
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= ST_BLANK;
			digit <= 3'h0;
			waitCount <= 32'h0;
			bus.address <= 3'h0;
			bus.writeData <= 8'h00;
			bus.writeStrobe <= 1'b0;
			bus.readStrobe <= 1'b0;
			turnCount <= 16'h0000;
		end else begin
			bus.writeStrobe <= 1'b0;
			bus.readStrobe <= 1'b0;
			case (state)
				ST_BLANK: begin
					// enable bit low blanks select and all latches once per frame
					bus.address <= fpd_pkg::LOC_SELECT;
					bus.writeData <= {4'h0, fpd_pkg::SELECT_RESET};
					bus.writeStrobe <= 1'b1;
					state <= ST_SELECT;
				end
				ST_SELECT: begin
					bus.address <= fpd_pkg::LOC_LOWER_SEG;
					bus.writeData <= digitSegments[digit][7:0];
					bus.writeStrobe <= 1'b1;
					state <= ST_LOWER;
				end
				ST_LOWER: begin
					bus.address <= fpd_pkg::LOC_UPPER_SEG;
					bus.writeData <= {3'h0, upperBars, digitSegments[digit][9:8]};
					bus.writeStrobe <= 1'b1;
					state <= ST_UPPER;
				end
				ST_UPPER: begin
					bus.address <= fpd_pkg::LOC_LIGHTBAR;
					bus.writeData <= lightbarWord;
					bus.writeStrobe <= 1'b1;
					state <= ST_BAR;
				end
				ST_BAR: begin
					bus.address <= fpd_pkg::LOC_SELECT;
					bus.writeData <= {4'h0, 1'b1, digit}; // only one lit
					bus.writeStrobe <= 1'b1;
					waitCount <= 32'h0;
					state <= ST_WAIT;
				end
				ST_WAIT: begin
					waitCount <= waitCount + 32'h1;
					if (waitCount == 32'(REFRESH_CYCLES - 8)) begin
						state <= ST_READ;
					end
				end
				ST_READ: begin
					bus.address <= fpd_pkg::LOC_PANEL_INPUT;
					bus.readStrobe <= 1'b1;
					state <= ST_TAKE;
				end
				ST_TAKE: begin
					state <= ST_CLEAR; // data arrives next cycle
				end
				ST_CLEAR: begin
					turnCount <= turnCount + {{13{bus.readData[2]}}, bus.readData[2:0]};
					bus.address <= fpd_pkg::LOC_KNOB_CLEAR;
					// alternate read and write clears so both paths are used
					if (digit[0]) begin
						bus.readStrobe <= 1'b1;
					end else begin
						bus.writeStrobe <= 1'b1;
					end
					digit <= digit + 3'h1;
					if (digit == 3'h7) begin
						state <= ST_BLANK;
					end else begin
						state <= ST_SELECT;
					end
				end
				default: state <= ST_SELECT;
			endcase
		end
	end

	// software-style button debounce over successive reads
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lastButtons <= 4'hF;
			stableCount <= 4'h0;
			pressedSwitches <= 4'h0;
		end else if (state == ST_CLEAR) begin
			lastButtons <= {bus.readData[7], bus.readData[5:3]};
			if ({bus.readData[7], bus.readData[5:3]} != lastButtons) begin
				stableCount <= 4'h0;
			end else if (stableCount == 4'(fpd_pkg::DEBOUNCE_READS)) begin
				pressedSwitches <= ~lastButtons;
			end else begin
				stableCount <= stableCount + 4'h1;
			end
		end
	end
endmodule : fpd_host
`default_nettype wire

// File: test/fpd_asserts.sv
// checker: bus and display drive relations of the front panel
`timescale 1ns/1ps
`default_nettype none
module fpd_asserts (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// host bus
	input wire logic [2:0] address,
	input wire logic [7:0] writeData,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	input wire logic [7:0] readData,
	// panel pins
	input wire logic [3:0] panelSwitchInputs,
	input wire logic [7:0] displaySelectN,
	input wire logic [9:0] segmentDrive,
	input wire logic [10:0] lightbarDrive
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_select_one_low: assert property ($onehot(~displaySelectN) || &displaySelectN)
		else $error("several displays selected");
	a_select_index: assert property (writeStrobe && address == 3'h0 && writeData[3]
		|=> ##1 displaySelectN == ~(8'h01 << $past(writeData[2:0], 2)))
		else $error("display index not decoded");
	a_blank_clears: assert property (writeStrobe && address == 3'h0 && !writeData[3]
		|=> ##1 &displaySelectN && segmentDrive == 10'h000 && lightbarDrive == 11'h000)
		else $error("blank did not clear drives");
	a_lower_segments: assert property (writeStrobe && address == 3'h1
		|=> ##1 segmentDrive[7:0] == $past(writeData, 2))
		else $error("lower segments wrong");
	a_upper_latch: assert property (writeStrobe && address == 3'h2
		|=> ##1 segmentDrive[9:8] == $past(writeData[1:0], 2)
		&& lightbarDrive[10:8] == $past(writeData[4:2], 2))
		else $error("upper latch split wrong");
	a_lightbar_latch: assert property (writeStrobe && address == 3'h3
		|=> ##1 lightbarDrive[7:0] == $past(writeData, 2))
		else $error("lightbar latch wrong");
	a_panel_read: assert property (readStrobe && address == 3'h5 && $stable(panelSwitchInputs)
		|=> readData[6] && {readData[7], readData[5:3]} == $past(panelSwitchInputs))
		else $error("panel buffer bits wrong");
	a_other_reads: assert property (readStrobe && address != 3'h5 |=> readData == 8'h00)
		else $error("read of other location not zero");
	a_reset_blank: assert property ($fell(rst)
		|-> &displaySelectN && segmentDrive == 10'h000 && lightbarDrive == 11'h000)
		else $error("drives lit after reset");
endmodule // fpd_asserts
`default_nettype wire

// File: test/tb_front_panel_display_knob_io.sv
// testbench: host and panel joined over the bus
`timescale 1ns/1ps
`default_nettype none
module tb_front_panel_display_knob_io;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic knobPhaseA = 1'b1;
	logic knobPhaseB = 1'b0;
	logic [3:0] panelSwitchInputs = 4'hF;
	logic [9:0] digitSegments [8] = '{default: 10'h000};
	logic [7:0] lightbarWord = 8'h00;
	logic [2:0] upperBars = 3'h0;
	logic [15:0] turnCount;
	logic [3:0] pressedSwitches;
	logic [7:0] displaySelectN;
	logic [9:0] segmentDrive;
	logic [10:0] lightbarDrive;
	logic [7:0] got;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	localparam int TEST_REFRESH = 100; // short refresh period keeps the run brief
	fpd_bus_if bus ();
	fpd_panel u_fpd_panel (.clock(clock), .rst(rst), .bus(bus), .knobPhaseA(knobPhaseA),
		.knobPhaseB(knobPhaseB), .panelSwitchInputs(panelSwitchInputs),
		.displaySelectN(displaySelectN), .segmentDrive(segmentDrive),
		.lightbarDrive(lightbarDrive));
	fpd_host #(.REFRESH_CYCLES(TEST_REFRESH)) u_fpd_host (.clock(clock), .rst(rst), .bus(bus),
		.digitSegments(digitSegments),
		.lightbarWord(lightbarWord), .upperBars(upperBars), .turnCount(turnCount),
		.pressedSwitches(pressedSwitches));
	fpd_asserts u_fpd_asserts (.clock(clock), .rst(rst), .address(bus.address),
		.writeData(bus.writeData), .writeStrobe(bus.writeStrobe), .readStrobe(bus.readStrobe),
		.readData(bus.readData), .panelSwitchInputs(panelSwitchInputs),
		.displaySelectN(displaySelectN), .segmentDrive(segmentDrive),
		.lightbarDrive(lightbarDrive));
	// clock
	always #2 clock = ~clock;
	// hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches = mismatches + 1;
			wrap_up();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		compares++;
		if (seen !== want) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	// knob pulses on phase A, direction held on phase B
	task automatic knob_steps(input logic dir, input int n);
		knobPhaseB <= dir;
		repeat (n) begin
			repeat (10) @(posedge clock);
			knobPhaseA <= 1'b0;
			repeat (10) @(posedge clock);
			knobPhaseA <= 1'b1;
		end
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		#1;
		check({8'h00, displaySelectN}, 16'h00FF);
		check({5'h00, lightbarDrive}, 16'h0000);
		check({6'h00, segmentDrive}, 16'h0000);
		$display("reset test done");
		@(posedge clock);
		lightbarWord <= 8'hA5;
		upperBars <= 3'h5;
		for (int i = 0; i < 3000 && lightbarDrive !== 11'h5A5; i++) @(posedge clock);
		repeat (50) @(posedge clock);
		check({5'h00, lightbarDrive}, 16'h05A5);
		$display("lightbar test done");
		// every segment and lightbar lit, as the host self-test starts
		foreach (digitSegments[i]) digitSegments[i] <= 10'h3FF;
		lightbarWord <= 8'hFF;
		upperBars <= 3'h7;
		for (int i = 0; i < 3000 && segmentDrive !== 10'h3FF; i++) @(posedge clock);
		repeat (50) @(posedge clock);
		check({6'h00, segmentDrive}, 16'h03FF);
		check({5'h00, lightbarDrive}, 16'h07FF);
		check({15'h0000, displaySelectN != 8'hFF &&
			(~displaySelectN & (~displaySelectN - 8'h01)) == 8'h00}, 16'h0001);
		// one segment alone, as the host then tests them one at a time
		foreach (digitSegments[i]) digitSegments[i] <= 10'h080;
		lightbarWord <= 8'h00;
		upperBars <= 3'h0;
		for (int i = 0; i < 3000 && segmentDrive !== 10'h080; i++) @(posedge clock);
		repeat (50) @(posedge clock);
		check({6'h00, segmentDrive}, 16'h0080);
		check({5'h00, lightbarDrive}, 16'h0000);
		$display("segment test done");
		// reset again in mid-run with a segment lit
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		check({6'h00, segmentDrive}, 16'h0000);
		check({8'h00, displaySelectN}, 16'h00FF);
		@(posedge clock);
		rst <= 1'b0;
		$display("mid-run reset test done");
		panelSwitchInputs <= 4'hA;
		repeat (20) @(posedge clock);
		#1;
		for (int i = 0; i < 3000 && !(bus.readStrobe === 1'b1 && bus.address === 3'h5); i++) begin
			@(posedge clock);
			#1;
		end
		@(posedge clock);
		#1;
		got = bus.readData;
		check({11'h000, got[7:3]}, 16'h001A);
		for (int i = 0; i < 3000 && pressedSwitches !== 4'h5; i++) @(posedge clock);
		check({12'h000, pressedSwitches}, 16'h0005);
		panelSwitchInputs <= 4'hF;
		$display("button test done");
		knob_steps(1'b0, 8);
		for (int i = 0; i < 3000 && !($signed(turnCount) > 0); i++) @(posedge clock);
		check({15'h0000, $signed(turnCount) > 0}, 16'h0001);
		knob_steps(1'b1, 24);
		for (int i = 0; i < 3000 && !($signed(turnCount) < 0); i++) @(posedge clock);
		check({15'h0000, $signed(turnCount) < 0}, 16'h0001);
		$display("knob test done");
		wrap_up();
	end
endmodule // tb_front_panel_display_knob_io
`default_nettype wire
